// ---- core_test_packet_control.sv ----
// Slave-side test packet decoder: control packet to core/array drive, status packet capture,
// address and tag-control packet decode for array tests.
// Assumes the test sequencer supplies core_clock_gate, data enable and packet strobes on clock.
// Behaviour
// - RAM test takes size, burst, direct, strobes.
// - Direct-write picks set bank, else RAM bank.
// - Bit 31 exposes core, resets rest.
// - Bits 30 and 28 enter RAM test.
// - Bits 29 and 28 enter tag test.
// - Bits 28 and 27 enter translation test.
// - RAM controls come from address bits.
// - Tag bits flush and select arrays.
// - Tag write, read strobes; valid stored.
// - Status upper bits report debug outputs.
// - Full view status shows probes, else core.
// - Bit 17 latched transparently by clock gate.
// - Bit 28 clock override, 27 translation enable.
// - Data-in enable gated by clock gate.
// - Byte latches gated; bus and pipe enables.
// - Bits 20..17 drive TAP; TCK gated.
// - Bits 16..12 drive watch and halt inputs.
// - Bit 7 address drive or clock config.
// - Bit 5 data drive, gated, or mode.
// - Stall gated; interrupts, abort, reset driven.
// - Test access only while slave selected.
// - Clock gate only in data access states.
// - Bits 31..29 low, and not both 28 and 27, select full test.
`timescale 1ns/1ps
`include "test_packet_defs.svh"
module core_test_packet_control
  import test_packet_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic bus_clock,
  input wire logic core_slave_select,
  input wire logic core_clock_gate,
  input wire logic sm_data_enable,
  input wire logic ctl_write,
  input wire logic [31:0] ctl_data,
  input wire logic addr_write,
  input wire logic [31:0] addr_data,
  input wire logic tag_write,
  input wire logic [31:0] tag_data,
  input wire logic [31:0] core_status_in,
  input wire logic [31:0] full_status_in,
  input wire logic data_out_drive_n,
  output logic [31:0] test_status_packet,
  output logic [2:0] test_mode,
  output logic hold_rest_reset,
  output logic fast_clock_sel,
  output logic [31:0] core_drive,
  output logic [1:0] ram_access_size,
  output logic ram_burst_flag,
  output logic direct_write_sel,
  output logic ram_wr,
  output logic ram_rd,
  output logic [3:0] ram_bank_sel,
  output logic [10:0] ram_addr,
  output logic [3:0] tag_flush,
  output logic [3:0] tag_array_pick,
  output logic tag_wr,
  output logic tag_rd,
  output logic tag_valid
);
  logic [31:0] ctl_q, adr_q, tag_q, status_q, status_d;
  logic sel_s1_q, sel_q, drive_latch;
  test_mode_e mode;

  // Select is a pin, so it is synchronised before use
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_s1_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sel_s1_q <= core_slave_select;
      sel_q <= sel_s1_q;
    end
  end

  // Packets only accepted while selected as test slave
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl_q <= `CTL_RESET;
      adr_q <= 32'h0000_0000;
      tag_q <= 32'h0000_0000;
      status_q <= 32'h0000_0000;
    end else begin
      if (sel_q && ctl_write) ctl_q <= ctl_data;
      if (sel_q && addr_write) adr_q <= addr_data;
      if (sel_q && tag_write) tag_q <= tag_data;
      status_q <= status_d;
    end
  end

  // Core test wins, then RAM, tag, translation; RAM takes bit 30 as the prose says
  wire core_req = ctl_q[`CTL_CORE_TEST];
  wire ram_req = ctl_q[`CTL_RAM_TEST] & ctl_q[`CTL_FCLK_OVR];
  wire tag_req = ctl_q[`CTL_TAG_TEST] & ctl_q[`CTL_FCLK_OVR];
  wire xl_req = ctl_q[`CTL_FCLK_OVR] & ctl_q[`CTL_XLATE];
  always_comb begin
    if (!sel_q) mode = MODE_FULL;
    else if (core_req) mode = MODE_CORE;
    else if (ram_req) mode = MODE_RAM;
    else if (tag_req) mode = MODE_TAG;
    else if (xl_req) mode = MODE_XLATE;
    else mode = MODE_FULL;
  end
  wire core_view = (mode == MODE_CORE);
  assign test_mode = mode;
  assign hold_rest_reset = sel_q && (mode != MODE_FULL);
  assign fast_clock_sel = sel_q && !core_view && ctl_q[`CTL_FCLK_OVR];

  // Bit 28 and gated pins; gate is high only in data access states
  wire din_n = ~(~ctl_q[`CTL_FCLK_OVR] & core_clock_gate);
  wire [3:0] bl = ctl_q[`CTL_BL_HI:`CTL_BL_LO] & {4{core_clock_gate}};
  wire tck = ctl_q[`CTL_TCK] & core_clock_gate & bus_clock;
  wire dbe = ctl_q[`CTL_DBE] & sm_data_enable & bus_clock;
  wire stall_n = ctl_q[`CTL_STALL] & core_clock_gate;
  assign core_drive = {
    ctl_q[31:29],
    core_view ? din_n : ctl_q[28],
    ctl_q[27:25],
    core_view ? bl : ctl_q[24:21],
    ctl_q[20:19],
    core_view ? tck : ctl_q[18],
    ctl_q[17:12],
    ctl_q[11:6],
    core_view ? dbe : ctl_q[5],
    ctl_q[4:2],
    core_view ? stall_n : ctl_q[1],
    ctl_q[0]
  };

  // RAM controls come from spare address-packet bits, tag controls from the tag-control packet
  wire ram_on = (mode == MODE_RAM);
  wire tag_on = (mode == MODE_TAG);
  assign ram_access_size = ram_on ? adr_q[`ADR_SIZE_HI:`ADR_SIZE_LO] : 2'h0;
  assign ram_burst_flag = ram_on & adr_q[`ADR_BURST];
  assign direct_write_sel = ram_on & adr_q[`ADR_DIRECT];
  assign ram_wr = ram_on & adr_q[`ADR_WR];
  assign ram_rd = ram_on & adr_q[`ADR_RD];
  assign ram_bank_sel = !ram_on ? 4'h0 : adr_q[`ADR_DIRECT] ? adr_q[`ADR_SET_BANK_PICK_HI:`ADR_SET_BANK_PICK_LO]
                      : adr_q[`ADR_RAM_BANK_PICK_HI:`ADR_RAM_BANK_PICK_LO];
  assign ram_addr = ram_on ? adr_q[`ADR_ADDR_HI:0] : 11'h000;
  assign tag_flush = tag_on ? tag_q[`TAG_FLUSH_HI:`TAG_FLUSH_LO] : 4'h0;
  assign tag_array_pick = tag_on ? tag_q[`TAG_SEL_HI:`TAG_SEL_LO] : 4'h0;
  assign tag_wr = tag_on & tag_q[`TAG_WR];
  assign tag_rd = tag_on & tag_q[`TAG_RD];
  assign tag_valid = tag_on & tag_q[`TAG_VALID];

  // Transparent capture of a strobe that is only valid in the data access cycle
  always_latch begin
    if (reset) drive_latch = 1'b1;
    else if (core_clock_gate) drive_latch = data_out_drive_n;
  end

  always_comb begin
    status_d = core_view ? core_status_in : full_status_in;
    if (!core_view) begin
      status_d[31] = 1'b0;
      status_d[3] = drive_latch;
    end
    status_d[17] = drive_latch;
  end
  assign test_status_packet = status_q;

  a_mode_core: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_q[31]) |-> (test_mode == MODE_CORE && hold_rest_reset))
    else $error("core test not entered");
  a_mode_ram: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_q[31:28] == 4'b0101) |-> test_mode == MODE_RAM)
    else $error("ram test not entered");
  a_mode_tag: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_q[31:28] == 4'b0011) |-> test_mode == MODE_TAG)
    else $error("tag test not entered");
  a_mode_xlate: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_q[31:27] == 5'b00011) |-> test_mode == MODE_XLATE)
    else $error("translation test not entered");
  a_bank_pick: assert property (@(posedge clock) disable iff (reset)
    (ram_on && adr_q[21]) |-> ram_bank_sel == adr_q[14:11])
    else $error("set bank not picked");
  a_stall_gate: assert property (@(posedge clock) disable iff (reset)
    (core_view && !core_clock_gate) |-> !core_drive[1])
    else $error("stall released outside data access");
  a_byte_gate: assert property (@(posedge clock) disable iff (reset)
    (core_view && !core_clock_gate) |-> core_drive[24:21] == 4'h0)
    else $error("byte latch outside data access");
  a_din_gate: assert property (@(posedge clock) disable iff (reset)
    (core_view && !core_clock_gate) |-> core_drive[28])
    else $error("data-in enable outside data access");
  a_ctl_load: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_write) |=> ctl_q == $past(ctl_data))
    else $error("control packet not loaded");
  a_tag_write: assert property (@(posedge clock) disable iff (reset)
    tag_on |-> (tag_wr == tag_q[2] && tag_valid == tag_q[0]))
    else $error("tag strobe mismatch");
  a_status_latch: assert property (@(posedge clock) disable iff (reset)
    core_clock_gate |=> test_status_packet[17] == $past(data_out_drive_n))
    else $error("status bit 17 not captured");
  a_mode_full: assert property (@(posedge clock) disable iff (reset)
    (sel_q && !ctl_q[31] && !(ctl_q[28] && (ctl_q[30] || ctl_q[29] || ctl_q[27]))) |-> test_mode == MODE_FULL)
    else $error("full test not selected");
  a_unsel_full: assert property (@(posedge clock) disable iff (reset)
    !sel_q |-> (test_mode == MODE_FULL && !hold_rest_reset))
    else $error("test mode while not selected");
  a_unsel_hold: assert property (@(posedge clock) disable iff (reset)
    (!sel_q && ctl_write) |=> ctl_q == $past(ctl_q))
    else $error("control packet taken while not selected");
  a_ram_size: assert property (@(posedge clock) disable iff (reset)
    ram_on |-> ram_access_size == adr_q[24:23])
    else $error("ram size mismatch");
  a_ram_strobes: assert property (@(posedge clock) disable iff (reset)
    ram_on |-> {ram_burst_flag, direct_write_sel, ram_wr, ram_rd} == adr_q[22:19])
    else $error("ram strobes mismatch");
  a_ram_bank: assert property (@(posedge clock) disable iff (reset)
    (ram_on && !adr_q[21]) |-> ram_bank_sel == adr_q[18:15])
    else $error("ram bank not picked");
  a_ram_addr: assert property (@(posedge clock) disable iff (reset)
    ram_on |-> ram_addr == adr_q[10:0])
    else $error("ram address mismatch");
  a_ram_idle: assert property (@(posedge clock) disable iff (reset)
    !ram_on |-> {ram_access_size, ram_burst_flag, direct_write_sel, ram_wr, ram_rd, ram_bank_sel, ram_addr} == 21'h0)
    else $error("ram controls active outside ram test");
  a_tag_flush: assert property (@(posedge clock) disable iff (reset)
    tag_on |-> tag_flush == tag_q[11:8])
    else $error("tag flush mismatch");
  a_tag_pick: assert property (@(posedge clock) disable iff (reset)
    tag_on |-> tag_array_pick == tag_q[7:4])
    else $error("tag select mismatch");
  a_tag_read: assert property (@(posedge clock) disable iff (reset)
    tag_on |-> tag_rd == tag_q[1])
    else $error("tag read strobe mismatch");
  a_tag_idle: assert property (@(posedge clock) disable iff (reset)
    !tag_on |-> {tag_flush, tag_array_pick, tag_wr, tag_rd, tag_valid} == 11'h0)
    else $error("tag controls active outside tag test");
  a_tck_gate: assert property (@(posedge clock) disable iff (reset)
    core_view |-> core_drive[18] == (ctl_q[18] & core_clock_gate & bus_clock))
    else $error("test clock not gated");
  a_dbe_gate: assert property (@(posedge clock) disable iff (reset)
    core_view |-> core_drive[5] == (ctl_q[5] & sm_data_enable & bus_clock))
    else $error("data drive not gated");
  a_full_pass: assert property (@(posedge clock) disable iff (reset)
    !core_view |-> core_drive == ctl_q)
    else $error("full view drive altered");
  a_tap_pass: assert property (@(posedge clock) disable iff (reset)
    (core_drive[20:19] == ctl_q[20:19] && core_drive[17] == ctl_q[17]))
    else $error("tap inputs mismatch");
  a_watch_pass: assert property (@(posedge clock) disable iff (reset)
    core_drive[16:12] == ctl_q[16:12])
    else $error("watch or halt inputs mismatch");
  a_bit7_pass: assert property (@(posedge clock) disable iff (reset)
    core_drive[7] == ctl_q[7])
    else $error("address drive bit mismatch");
  a_irq_pass: assert property (@(posedge clock) disable iff (reset)
    (core_drive[4:2] == ctl_q[4:2] && core_drive[0] == ctl_q[0]))
    else $error("interrupt or reset input mismatch");
  a_fclk_sel: assert property (@(posedge clock) disable iff (reset)
    fast_clock_sel == (sel_q && !core_view && ctl_q[28]))
    else $error("clock override mismatch");
  a_core_over: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_q[31] && ctl_q[28]) |-> !fast_clock_sel)
    else $error("clock override in core test");
  a_status_top: assert property (@(posedge clock) disable iff (reset)
    core_view |=> test_status_packet[31] == $past(core_status_in[31]))
    else $error("bus disable not reported");
  a_status_full31: assert property (@(posedge clock) disable iff (reset)
    !core_view |=> !test_status_packet[31])
    else $error("status bit 31 set in full view");
  a_status_probe: assert property (@(posedge clock) disable iff (reset)
    !core_view |=> test_status_packet[16:4] == $past(full_status_in[16:4]))
    else $error("probe bits not reported");
  a_status_bit3: assert property (@(posedge clock) disable iff (reset)
    !core_view |=> test_status_packet[3] == test_status_packet[17])
    else $error("status bit 3 not latched");
  a_array_hold: assert property (@(posedge clock) disable iff (reset)
    (test_mode == MODE_RAM || test_mode == MODE_TAG || test_mode == MODE_XLATE) |-> hold_rest_reset)
    else $error("rest not held in array test");
  a_hold_full: assert property (@(posedge clock) disable iff (reset)
    test_mode == MODE_FULL |-> !hold_rest_reset)
    else $error("rest held in full test");
  a_din_open: assert property (@(posedge clock) disable iff (reset)
    (core_view && core_clock_gate) |-> core_drive[28] == ctl_q[28])
    else $error("data-in enable blocked in data access");
  a_byte_open: assert property (@(posedge clock) disable iff (reset)
    (core_view && core_clock_gate) |-> core_drive[24:21] == ctl_q[24:21])
    else $error("byte latch blocked in data access");
  a_stall_open: assert property (@(posedge clock) disable iff (reset)
    (core_view && core_clock_gate) |-> core_drive[1] == ctl_q[1])
    else $error("stall blocked in data access");
  a_core_pass: assert property (@(posedge clock) disable iff (reset)
    core_view |-> core_drive[27:25] == ctl_q[27:25])
    else $error("bus or pipe enable mismatch");
  a_ram_first: assert property (@(posedge clock) disable iff (reset)
    (sel_q && ctl_q[31:28] == 4'b0111) |-> test_mode == MODE_RAM)
    else $error("ram test not preferred");
  c_ram_direct: cover property (@(posedge clock) disable iff (reset) ram_on && direct_write_sel);
  c_core: cover property (@(posedge clock) disable iff (reset) test_mode == MODE_CORE);
  c_ram_write: cover property (@(posedge clock) disable iff (reset) ram_wr);
  c_tag_flush: cover property (@(posedge clock) disable iff (reset) tag_flush != 4'h0);
  c_xlate: cover property (@(posedge clock) disable iff (reset) test_mode == MODE_XLATE);
endmodule // core_test_packet_control

// ---- test_packet_defs.svh ----
// Bit positions for the test control, address and tag-control packets, and the control packet reset value.
// Assumes inclusion by the test packet block only.
`ifndef TEST_PACKET_DEFS_SVH
`define TEST_PACKET_DEFS_SVH
`define CTL_CORE_TEST 31
`define CTL_RAM_TEST 30
`define CTL_TAG_TEST 29
`define CTL_FCLK_OVR 28
`define CTL_XLATE 27
`define CTL_TBE 26
`define CTL_APE 25
`define CTL_BL_HI 24
`define CTL_BL_LO 21
`define CTL_TMS 20
`define CTL_TDI 19
`define CTL_TCK 18
`define CTL_TRST 17
`define CTL_EXT1 16
`define CTL_EXT0 15
`define CTL_HALTRQ 14
`define CTL_BRK 13
`define CTL_HALTEN 12
`define CTL_IRQ_SYNC_CFG 11
`define CTL_ENDIAN 10
`define CTL_CPA 9
`define CTL_CPB 8
`define CTL_ABE 7
`define CTL_ALE 6
`define CTL_DBE 5
`define CTL_FIQ 4
`define CTL_IRQ 3
`define CTL_ABORT 2
`define CTL_STALL 1
`define CTL_RST 0
`define ADR_SIZE_HI 24
`define ADR_SIZE_LO 23
`define ADR_BURST 22
`define ADR_DIRECT 21
`define ADR_WR 20
`define ADR_RD 19
`define ADR_RAM_BANK_PICK_HI 18
`define ADR_RAM_BANK_PICK_LO 15
`define ADR_SET_BANK_PICK_HI 14
`define ADR_SET_BANK_PICK_LO 11
`define ADR_ADDR_HI 10
`define TAG_FLUSH_HI 11
`define TAG_FLUSH_LO 8
`define TAG_SEL_HI 7
`define TAG_SEL_LO 4
`define TAG_WR 2
`define TAG_RD 1
`define TAG_VALID 0
`define CTL_RESET 32'h0000_0081
`endif

// ---- test_packet_pkg.sv ----
// Types shared by the test packet block.
// Assumes the defs header for bit positions.
package test_packet_pkg;
  typedef enum logic [2:0] {
    MODE_FULL,
    MODE_CORE,
    MODE_RAM,
    MODE_TAG,
    MODE_XLATE
  } test_mode_e;
endpackage

// ---- test_sequencer_model.sv ----
// Model of the test sequencer beside the block: gate phases and status sources.
// Assumes one clock and an active-high reset from the bench.
`timescale 1ns/1ps
module test_sequencer_model (
  input wire logic clock,
  input wire logic reset,
  output logic bus_clock,
  output logic core_clock_gate,
  output logic sm_data_enable,
  output logic [31:0] core_status_in,
  output logic [31:0] full_status_in,
  output logic data_out_drive_n
);
  logic [1:0] phase_q;
  // Falling edge, so the block sees settled levels at its sampling edge
  always_ff @(negedge clock or posedge reset) begin
    if (reset) phase_q <= 2'h0;
    else phase_q <= phase_q + 2'h1;
  end
  assign core_clock_gate = (phase_q == 2'h3);
  assign bus_clock = phase_q[0];
  assign sm_data_enable = phase_q[1];
  assign core_status_in = 32'hC3A5_5A3C;
  assign full_status_in = 32'h96E1_1E69;
  assign data_out_drive_n = 1'b0;
endmodule // test_sequencer_model

// ---- test_core_test_packet_control.sv ----
// Testbench for the test packet block: packet writes, mode, decode and status checks.
// Assumes the sequencer model supplies gate phases and status sources.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_core_test_packet_control;
  import test_packet_pkg::*;
  logic clock, reset, bus_clock, sel, gate, sm_en, cw, aw, tw, drv_n;
  logic [31:0] cd, ad, td, cst, fst, status, drive;
  logic [2:0] mode;
  logic hold, fcs, burst, direct, ram_wr, ram_rd, tag_wr, tag_rd, tag_valid;
  logic [1:0] size;
  logic [3:0] bank, flush, pick;
  logic [10:0] addr;
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] mv [6] = '{32'h8000_0000, 32'h5000_0000, 32'h3000_0000, 32'h1800_0000, 32'hF800_0000, 32'h7000_0000};
  logic [2:0] me [6] = '{MODE_CORE, MODE_RAM, MODE_TAG, MODE_XLATE, MODE_CORE, MODE_RAM};
  test_sequencer_model test_sequencer_model_i (.clock(clock), .reset(reset), .bus_clock(bus_clock),
    .core_clock_gate(gate), .sm_data_enable(sm_en), .core_status_in(cst), .full_status_in(fst),
    .data_out_drive_n(drv_n));
  core_test_packet_control core_test_packet_control_i (.clock(clock), .reset(reset), .bus_clock(bus_clock),
    .core_slave_select(sel), .core_clock_gate(gate), .sm_data_enable(sm_en), .ctl_write(cw), .ctl_data(cd),
    .addr_write(aw), .addr_data(ad), .tag_write(tw), .tag_data(td), .core_status_in(cst),
    .full_status_in(fst), .data_out_drive_n(drv_n), .test_status_packet(status), .test_mode(mode),
    .hold_rest_reset(hold), .fast_clock_sel(fcs), .core_drive(drive), .ram_access_size(size),
    .ram_burst_flag(burst), .direct_write_sel(direct), .ram_wr(ram_wr), .ram_rd(ram_rd),
    .ram_bank_sel(bank), .ram_addr(addr), .tag_flush(flush), .tag_array_pick(pick), .tag_wr(tag_wr),
    .tag_rd(tag_rd), .tag_valid(tag_valid));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Packet write: k picks control, address or tag packet
  task automatic wr(input int k, input logic [31:0] v);
    @(negedge clock);
    {cd, ad, td} = {v, v, v};
    {cw, aw, tw} = {k == 0, k == 1, k == 2};
    @(negedge clock);
    {cw, aw, tw} = 3'h0;
    repeat (2) @(negedge clock);
  endtask
  // Status read: waits five cycles, longer than one four-phase gate sequence, so the latched bit is settled
  task automatic rd(input logic [31:0] e);
    repeat (5) @(negedge clock);
    `CHK(status, e)
  endtask
  task automatic wait_gate(input logic lvl);
    do begin @(negedge clock); #1; end while (gate !== lvl);
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
  initial begin
    {reset, sel, cw, aw, tw, cd, ad, td} = {3'h4, 2'h0, 96'h0};
    repeat (16) @(negedge clock);
    reset = 1'b0;
    sel = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(mode, MODE_FULL)
    `CHK(drive, 32'h0000_0081)
    wr(0, 32'h0001_F0A1);
    `CHK(drive, 32'h0001_F0A1)
    rd(32'h16E1_1E61);
    for (int i = 0; i < 6; i++) begin
      wr(0, mv[i]);
      `CHK({mode, hold, fcs}, {me[i], 1'b1, me[i] != MODE_CORE && mv[i][28]})
    end
    wr(1, 32'h0155_2DA3);
    `CHK({size, burst, direct, ram_wr, ram_rd, bank, addr}, {2'h2, 4'hA, 4'hA, 11'h5A3})
    wr(1, 32'h016D_2DA3);
    `CHK({size, burst, direct, ram_wr, ram_rd, bank, addr}, {2'h2, 4'hD, 4'h5, 11'h5A3})
    `CHK({flush, pick, tag_wr, tag_rd, tag_valid}, 11'h000)
    wr(0, 32'h3000_0000);
    wr(2, 32'h0000_0AB5);
    `CHK({flush, pick, tag_wr, tag_rd, tag_valid}, {4'hA, 4'hB, 3'h5})
    `CHK({size, burst, direct, ram_wr, ram_rd, bank, addr}, 21'h0)
    wr(0, 32'h81E5_F022);
    wait_gate(1'b1);
    `CHK(drive, 32'h81E5_F022)
    wait_gate(1'b0);
    `CHK(drive & 32'h01E4_0022, 32'h0)
    rd(32'hC3A5_5A3C);
    wr(0, 32'h0001_F0A1);
    sel = 1'b0;
    // Select passes two flops, so let it settle low before the refused write
    repeat (3) @(negedge clock);
    wr(0, 32'h8000_0000);
    `CHK(hold, 1'b0)
    sel = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(mode, MODE_FULL)
    finish_test();
  end
endmodule // test_core_test_packet_control
